// ===== rtl/cell_rx_defines.vh
// Constants for the cell receive port: pin widths, strap and tie-off values.
// Assumes inclusion by bare name from the design files.
`ifndef CELL_RX_DEFINES_VH
`define CELL_RX_DEFINES_VH
`define CRX_BYTE_W        8
`define CRX_ADDR_W        5
`define CRX_ADDR_LOW_W    2
`define CRX_NULL_ADDR     5'h1F
`define CRX_DEF_ADDR      5'h00
`define CRX_STRAP_RESET   1'b0
`define CRX_ENB_TIEOFF    1'b1
`define CRX_SOC_TIEOFF    1'b0
`define CRX_CLK_TIEOFF    1'b0
`define CRX_CLAV_NO_ROOM  1'b0
`define CRX_CLAV_ROOM     1'b1
`define CRX_SYNC_STAGES   3
`define CRX_STRAP_SETTLE  3'h4
`endif

// ===== rtl/pin_sync.v
// Three-flop pin synchroniser with agreement filter on the last two stages.
// Assumes an asynchronous input and the block clock with clock enable.
`timescale 1ns/1ps
`include "cell_rx_defines.vh"

module pin_sync
#(
    parameter        WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
    input  wire             clk_i,
    input  wire             nrst_i,
    input  wire             ce_i,
    input  wire [WIDTH-1:0] d_i,
    output reg  [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] s1_reg;   // Metastable stage, read only by s2
    reg [WIDTH-1:0] s2_reg;   // Second stage
    reg [WIDTH-1:0] s3_reg;   // Third stage

    ////////////////////////////////////////////////////////////////////////
    // Stages; output follows only when stages two and three agree
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            q_o    <= INIT;
        end
        else if (ce_i)
        begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Per bit agreement, so a one-sample glitch never reaches the core
            q_o    <= (s2_reg & s3_reg) | (q_o & (s2_reg | s3_reg));
        end
    end

endmodule

// ===== rtl/cell_rx_port.v
// Receive side of a cell bus slave port: samples bytes on link clock edges.
// Assumes link clock well below clk_i/2 (125 ns vs 8 ns) and a room input.
`timescale 1ns/1ps
`include "cell_rx_defines.vh"

// Overview of operation
// - Room output high only when addressed and not full, low otherwise
// - Sample from the cycle after enable
// - Start marker flags first byte of cell
// - Arm a transfer only when five-bit address matches; the cell then runs until enable goes high
// - All five address bits valid only with strap
// - Strap low ties off clock, room, enable, start
// - Strap low ties off all five address bits
// - Capture bytes on rising link clock edge
module cell_rx_port
#(
    parameter [`CRX_ADDR_W-1:0] MY_ADDR = `CRX_DEF_ADDR
)
(
    input  wire                    clk_i,
    input  wire                    nrst_i,
    input  wire                    ce_i,
    input  wire                    cell_port_strap_pin_i,
    input  wire                    rx_cell_clock_i,
    input  wire                    rx_sample_enable_n_i,
    input  wire                    rx_cell_start_i,
    input  wire [`CRX_BYTE_W-1:0]  rx_cell_byte_i,
    input  wire [`CRX_ADDR_W-1:0]  rx_slave_select_i,
    input  wire                    room_i,
    output reg                     rx_room_available_o,
    output reg                     rx_room_available_oe_o,
    output reg                     cell_port_enable_strap_o,
    output reg  [`CRX_BYTE_W-1:0]  byte_o,
    output reg                     byte_valid_o,
    output reg                     cell_start_o
);

    localparam SW = 1 + 1 + 1 + `CRX_BYTE_W + `CRX_ADDR_W;
    localparam [SW-1:0] SYNC_INIT = {`CRX_CLK_TIEOFF, `CRX_ENB_TIEOFF,
                                     `CRX_SOC_TIEOFF, {`CRX_BYTE_W{1'b0}},
                                     `CRX_NULL_ADDR};

    // Transfer state machine
    localparam [1:0] ST_IDLE   = 2'h0;   // Not selected for transfer
    localparam [1:0] ST_ARMED  = 2'h1;   // Enable seen, sample from next edge
    localparam [1:0] ST_SAMPLE = 2'h2;   // Sampling each edge while enabled

    wire [SW-1:0]  raw_bus;               // Raw pin group
    wire [SW-1:0]  sync_bus;              // Filtered pin group
    wire           lclk_s;                // Synced link clock
    wire           enb_n_s;               // Synced enable, active low
    wire           soc_s;                 // Synced start marker
    wire [`CRX_BYTE_W-1:0] data_s;        // Synced data byte
    wire [`CRX_ADDR_W-1:0] addr_s;        // Synced address
    reg            strap_reg;             // Strap caught after reset release
    reg            strap_done_reg;        // Strap captured flag
    wire           strap_s;               // Filtered strap pin
    reg  [2:0]     settle_reg;            // Edges waited for the strap sync
    reg            lclk_d_reg;            // Previous link clock level
    reg  [1:0]     state_reg;             // Transfer state
    reg  [1:0]     state_next;
    reg  [`CRX_ADDR_W-1:0] eff_addr;      // Address after tie-off
    reg            enb_n_eff;             // Enable after tie-off
    reg            soc_eff;               // Start after tie-off
    reg            lclk_eff;              // Clock after tie-off
    wire           rise;                  // Link clock rising edge
    wire           selected;              // Our address on the bus

    assign raw_bus = {rx_cell_clock_i, rx_sample_enable_n_i, rx_cell_start_i,
                      rx_cell_byte_i, rx_slave_select_i};

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; link clock is sampled, not used as a clock
    pin_sync #(.WIDTH(SW), .INIT(SYNC_INIT)) u_sync
    (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ce_i   (ce_i),
        .d_i    (raw_bus),
        .q_o    (sync_bus)
    );

    assign lclk_s  = sync_bus[SW-1];
    assign enb_n_s = sync_bus[SW-2];
    assign soc_s   = sync_bus[SW-3];
    assign data_s  = sync_bus[`CRX_ADDR_W +: `CRX_BYTE_W];
    assign addr_s  = sync_bus[`CRX_ADDR_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Strap pin synchroniser; the strap is a board pin like the link pins,
    // so it gets the same three flops and agreement filter
    pin_sync #(.WIDTH(1), .INIT(`CRX_STRAP_RESET)) u_strap_sync
    (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ce_i   (ce_i),
        .d_i    (cell_port_strap_pin_i),
        .q_o    (strap_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap capture once the strap synchroniser has filled after reset.
    // Latched a single time: moving the strap later has no effect, which
    // keeps the address pins from changing role in mid-cell.
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // Async reset loads constants only
            strap_reg      <= `CRX_STRAP_RESET;
            strap_done_reg <= 1'b0;
            settle_reg     <= 3'h0;
        end
        else if (ce_i && !strap_done_reg)
        begin
            if (settle_reg == `CRX_STRAP_SETTLE)
            begin
                // Synchroniser output is settled from this edge on
                strap_reg      <= strap_s;
                strap_done_reg <= 1'b1;
            end
            else
            begin
                // Still flushing the reset value out of the stages
                settle_reg <= settle_reg + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tie-offs while the port is disabled by the strap
    always @*
    begin
        if (strap_reg)
        begin
            eff_addr  = addr_s;
            enb_n_eff = enb_n_s;
            soc_eff   = soc_s;
            lclk_eff  = lclk_s;
        end
        else
        begin
            // Whole address tied to the null address; enable, start, clock tied off
            eff_addr  = `CRX_NULL_ADDR;
            enb_n_eff = `CRX_ENB_TIEOFF;
            soc_eff   = `CRX_SOC_TIEOFF;
            lclk_eff  = `CRX_CLK_TIEOFF;
        end
    end

    // Null address never selects, so up to 31 slaves share the bus
    assign selected = strap_reg && (eff_addr == MY_ADDR)
                      && (MY_ADDR != `CRX_NULL_ADDR);
    assign rise = lclk_eff & ~lclk_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Next state, evaluated only on link clock rising edges
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                // Low enable requests sampling from the next edge
                if (!enb_n_eff && selected)
                    state_next = ST_ARMED;
            end
            ST_ARMED:
            begin
                state_next = enb_n_eff ? ST_IDLE : ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                if (enb_n_eff)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequential core: edge detect, state, capture and room output
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            lclk_d_reg               <= `CRX_CLK_TIEOFF;
            state_reg                <= ST_IDLE;
            byte_o                   <= {`CRX_BYTE_W{1'b0}};
            byte_valid_o             <= 1'b0;
            cell_start_o             <= 1'b0;
            rx_room_available_o      <= `CRX_CLAV_NO_ROOM;
            rx_room_available_oe_o   <= 1'b0;
            cell_port_enable_strap_o <= `CRX_STRAP_RESET;
        end
        else if (ce_i)
        begin
            // Follows the synced pin even while tied off, so latching the
            // strap with the link clock high gives no false edge
            lclk_d_reg               <= lclk_s;
            cell_port_enable_strap_o <= strap_reg;
            byte_valid_o             <= 1'b0;
            cell_start_o             <= 1'b0;
            if (rise)
            begin
                state_reg <= state_next;
                // Capture on each edge once armed and still enabled.
                // Selection is checked when arming only; the cell then
                // runs until the enable goes inactive.
                if (state_reg != ST_IDLE && !enb_n_eff)
                begin
                    byte_o       <= data_s;
                    byte_valid_o <= 1'b1;
                    cell_start_o <= soc_eff;
                end
            end
            // Room reported only while addressed; otherwise released
            rx_room_available_oe_o <= selected;
            rx_room_available_o    <= (selected && room_i) ?
                                      `CRX_CLAV_ROOM : `CRX_CLAV_NO_ROOM;
        end
    end

endmodule

// ===== tb/cell_rx_port_sva.sv
// Checker for the cell receive port, bound to its ports.
// Assumes the link pins move far slower than clk_i.
`timescale 1ns/1ps
module cell_rx_port_sva
#(
    parameter [4:0] MY_ADDR = 5'h00
)
(
    input wire       clk_i,
    input wire       nrst_i,
    input wire       ce_i,
    input wire       rx_sample_enable_n_i,
    input wire [4:0] rx_slave_select_i,
    input wire       room_i,
    input wire       rx_room_available_o,
    input wire       rx_room_available_oe_o,
    input wire       cell_port_enable_strap_o,
    input wire [7:0] byte_o,
    input wire       byte_valid_o,
    input wire       cell_start_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    // Frozen cycles are skipped: outputs hold on purpose while ce_i is low
    default disable iff (!nrst_i || !ce_i);
    // Eight cycles flush the three-flop syncs
    sequence s_foreign;
        (rx_slave_select_i != MY_ADDR)[*8];
    endsequence
    sequence s_idle;
        rx_sample_enable_n_i[*8];
    endsequence
    sequence s_room_steady;
        $stable(room_i)[*6];
    endsequence
    property p_float_low; !rx_room_available_oe_o |-> !rx_room_available_o; endproperty
    a_float_low: assert property (p_float_low) else $error("room set while floated");
    property p_foreign_float; s_foreign |-> !rx_room_available_oe_o; endproperty
    a_foreign_float: assert property (p_foreign_float) else $error("pin driven unselected");
    property p_foreign_quiet; s_foreign |-> !byte_valid_o; endproperty
    a_foreign_quiet: assert property (p_foreign_quiet) else $error("capture unselected");
    property p_idle_quiet; s_idle |-> !byte_valid_o; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("capture while idle");
    property p_strap_off;
        !cell_port_enable_strap_o |-> !rx_room_available_oe_o && !byte_valid_o;
    endproperty
    a_strap_off: assert property (p_strap_off) else $error("port active unstrapped");
    property p_room_level;
        s_room_steady ##0 rx_room_available_oe_o |-> rx_room_available_o == room_i;
    endproperty
    a_room_level: assert property (p_room_level) else $error("room level wrong");
    property p_start_byte; cell_start_o |-> byte_valid_o; endproperty
    a_start_byte: assert property (p_start_byte) else $error("start without byte");
    property p_one_pulse; byte_valid_o |=> !byte_valid_o; endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("byte pulse too long");
    property p_byte_hold; !byte_valid_o |-> $stable(byte_o); endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte moved unflagged");
endmodule
bind cell_rx_port cell_rx_port_sva #(.MY_ADDR(MY_ADDR)) u_sva (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .rx_sample_enable_n_i(rx_sample_enable_n_i),
    .rx_slave_select_i(rx_slave_select_i), .room_i(room_i),
    .rx_room_available_o(rx_room_available_o), .rx_room_available_oe_o(rx_room_available_oe_o),
    .cell_port_enable_strap_o(cell_port_enable_strap_o), .byte_o(byte_o),
    .byte_valid_o(byte_valid_o), .cell_start_o(cell_start_o)
);

// ===== tb/cell_master_model.sv
// Behavioural master on the cell bus: link clock, enable, start, data, address.
// Clock stands low between frames; the idle edge shows the last byte inverted, then data rests on the last byte.
`timescale 1ns/1ps
module cell_master_model
(
    output logic       lclk_o,
    output logic       enb_n_o,
    output logic       soc_o,
    output logic [7:0] data_o,
    output logic [4:0] sel_o
);
    initial {lclk_o, enb_n_o, soc_o, data_o, sel_o} = {3'b010, 8'h5A, 5'h1F};
    // One 125 ns link period; values launch before the rise
    task automatic tick(input logic en_n, input logic s, input logic [7:0] d);
        {enb_n_o, soc_o, data_o} = {en_n, s, d};
        #62.5 lclk_o = 1'b1;
        #62.5 lclk_o = 1'b0;
    endtask
    task automatic set_sel(input logic [4:0] a);
        sel_o = a;
    endtask
    // Arm edge, n bytes with start on the first, then an idle edge
    task automatic send_cell(input logic [4:0] a, input int n, input logic [7:0] base);
        sel_o = a;
        tick(1'b0, 1'b0, ~data_o);
        for (int i = 0; i < n; i++)
            tick(1'b0, i == 0, 8'(base + i));
        tick(1'b1, 1'b0, ~data_o);
        data_o = ~data_o;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the cell receive port with a behavioural master.
// Assumes the port's fixed sync latency stays under a dozen clocks.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       strap = 1'b0;
    logic       room = 1'b0;
    logic       ce = 1'b1;
    wire        lclk, enb_n, soc, room_o, oe, strap_o, bv, cs;
    wire  [7:0] data, byte_o;
    wire  [4:0] sel;
    int         bad_count = 0;
    int         n_tests = 0;
    logic [7:0] got[$];
    logic       gsoc[$];
    always #4 clk_i = ~clk_i;
    cell_master_model MST (.lclk_o(lclk), .enb_n_o(enb_n), .soc_o(soc), .data_o(data),
        .sel_o(sel));
    cell_rx_port #(.MY_ADDR(5'h03)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
        .cell_port_strap_pin_i(strap), .rx_cell_clock_i(lclk), .rx_sample_enable_n_i(enb_n),
        .rx_cell_start_i(soc), .rx_cell_byte_i(data), .rx_slave_select_i(sel), .room_i(room),
        .rx_room_available_o(room_o), .rx_room_available_oe_o(oe),
        .cell_port_enable_strap_o(strap_o), .byte_o(byte_o), .byte_valid_o(bv),
        .cell_start_o(cs));
    // Collect pulses mid-cycle, clear of edge races
    always @(negedge clk_i)
        if (bv === 1'b1)
        begin
            got.push_back(byte_o);
            gsoc.push_back(cs);
        end
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        nrst_i = 1'b0;
        strap = s;
        repeat (16) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        `CHK(strap_o, s, "strap copy")
    endtask
    task automatic check_room(input logic [4:0] a, input logic r, input logic exp_oe);
        room = r;
        MST.set_sel(a);
        repeat (12) @(negedge clk_i);
        `CHK(oe, exp_oe, "pin enable")
        `CHK(room_o, r & exp_oe, "room level")
    endtask
    // Clock enable low must hold the room output against a room change
    task automatic check_freeze();
        room = 1'b1;
        MST.set_sel(5'h03);
        repeat (12) @(negedge clk_i);
        ce = 1'b0;
        room = 1'b0;
        repeat (12) @(negedge clk_i);
        `CHK(room_o, 1'b1, "room frozen")
        ce = 1'b1;
        repeat (12) @(negedge clk_i);
        `CHK(room_o, 1'b0, "room after thaw")
    endtask
    // Wait of up to 40 cycles, cut short only by a surplus byte, then content and start marks
    task automatic run_cell(input logic [4:0] a, input int n, input int want);
        got.delete();
        gsoc.delete();
        MST.send_cell(a, n, 8'hC0);
        for (int i = 0; i < 40 && got.size() <= want; i++) @(negedge clk_i);
        `CHK(got.size(), want, "byte count")
        if (got.size() < want) tally_and_finish();
        for (int i = 0; i < want; i++)
        begin
            `CHK(got[i], 8'(8'hC0 + i), "byte value")
            `CHK(gsoc[i], i == 0, "start mark")
        end
    endtask
    initial
    begin
        do_reset(1'b1);
        check_room(5'h03, 1'b1, 1'b1);
        check_room(5'h03, 1'b0, 1'b1);
        check_freeze();
        check_room(5'h02, 1'b1, 1'b0);
        run_cell(5'h03, 6, 6);
        run_cell(5'h03, 1, 1);
        run_cell(5'h02, 6, 0);
        run_cell(5'h13, 6, 0);
        do_reset(1'b0);
        check_room(5'h03, 1'b1, 1'b0);
        run_cell(5'h03, 6, 0);
        tally_and_finish();
    end
endmodule
